// ### bench/ufbc_peer.sv
// ufbc_peer: remote asynchronous transmitter/receiver on the serial lines.
// assumes the caller gives bit time in clocks and the idle level.
`timescale 1ns/1ns
`default_nettype none
module ufbc_peer (
  // clock
  input  wire logic clk_i,
  // serial lines as seen from the far side
  input  wire logic line_in_i,
  output var logic  line_out_o
);
  initial line_out_o = 1'b1;
  task automatic idle_at(input logic v);
    line_out_o <= v;
  endtask
  // one level per bit time, first level first
  task automatic send(input logic [12:0] lv, input int n, input int bt, input logic idle);
    for (int k = 0; k < n; k++)
    begin
      line_out_o <= lv[k];
      repeat (bt) @(posedge clk_i);
    end
    line_out_o <= idle;
  endtask
  // samples mid-bit; a start that never comes stops the wait after 4000 clocks, then samples the idle level
  task automatic recv(input int n, input int bt, input logic idle, output logic [12:0] lv);
    int w;
    lv = 13'h0000;
    w = 0;
    while (line_in_i === idle && w < 4000)
    begin
      @(posedge clk_i);
      w++;
    end
    repeat (bt / 2) @(posedge clk_i);
    for (int k = 0; k < n; k++)
    begin
      lv[k] = line_in_i;
      repeat (bt) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ### bench/ufbc_top_sva.sv
// ufbc_top_sva: port-level checker for ufbc_top.
// assumes the mode register is written only while the serial lines are idle.
`timescale 1ns/1ns
`default_nettype none
module ufbc_top_sva
  import ufbc_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  // clock, reset and apb
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // serial lines
  input wire logic        serial_receive_line_i,
  input wire logic        serial_transmit_line_o
);
  logic [4:0] mode_r;
  logic       take;
  logic       wr_mode;
  // writes land at the completing edge, where pready is high
  assign take    = psel_i && penable_i && pready_o;
  assign wr_mode = take && pwrite_i && paddr_i == UFBC_MODE_ADDR;
  // ----
  // shadow of mode bits; auto-baud bit left out as hardware clears it
  // ----
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      mode_r <= 5'h00;
    else if (wr_mode)
      mode_r <= pwdata_i[4:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence access_s; psel_i && penable_i && !pready_o; endsequence
  sequence hold_s; $stable(serial_transmit_line_o) [*3]; endsequence
  access_wait_a: assert property (access_s |=> pready_o)
    else $error("ready missing after access");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (!(psel_i && penable_i) |=> !pready_o)
    else $error("ready without access");
  unmapped_err_a: assert property (access_s ##0 (!pwrite_i && paddr_i > UFBC_STATUS_ADDR)
    |=> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped read not refused");
  mapped_ok_a: assert property (access_s ##0 (paddr_i <= UFBC_STATUS_ADDR
    && paddr_i[1:0] == 2'h0) |=> !pslverr_o) else $error("mapped access refused");
  mode_read_a: assert property (
    access_s ##0 (!pwrite_i && paddr_i == UFBC_MODE_ADDR) |=> prdata_o[4:0] == mode_r)
    else $error("mode readback differs");
  reset_idle_a: assert property ($rose(rst_n_i) |-> serial_transmit_line_o)
    else $error("transmit line not idle high after reset");
  idle_level_a: assert property (wr_mode |=> ##2 serial_transmit_line_o == !mode_r[4])
    else $error("transmit idle level wrong");
  bit_min_a: assert property ($changed(serial_transmit_line_o) |=> hold_s)
    else $error("transmit bit shorter than four clocks");
endmodule
bind ufbc_top ufbc_top_sva #(.DIV_WIDTH(DIV_WIDTH)) chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .serial_receive_line_i(serial_receive_line_i),
  .serial_transmit_line_o(serial_transmit_line_o));
`default_nettype wire

// ### bench/ufbc_top_tb.sv
// ufbc_top_tb: self-checking bench for ufbc_top with a far-side serial peer.
// assumes the register map and two-cycle apb access of the package.
`timescale 1ns/1ns
`default_nettype none
module ufbc_top_tb
  import ufbc_pkg::*;
();
  localparam int DIVV = 1;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx;
  logic        tx;
  logic [31:0] seed;
  int          mismatches;
  int          n_checks;
  int          exp_q[$];
  ufbc_top #(.DIV_WIDTH(16)) uut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .serial_receive_line_i(rx), .serial_transmit_line_o(tx));
  ufbc_peer peer (.clk_i(clk), .line_in_i(tx), .line_out_o(rx));
  always #25 clk = ~clk;
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // release is followed by one idle edge so no signal is set twice per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // line levels of one frame, start bit first
  function automatic logic [12:0] frame_of(input int d, input int pds, input int stp,
                                           input logic inv, output int n);
    logic [12:0] v;
    v = 13'h0000;
    n = 1;
    for (int j = 0; j < ((pds == 3) ? 9 : 8); j++)
      v[n++] = d[j];
    if (pds == 1 || pds == 2)
      v[n++] = ^d[7:0] ^ (pds == 2);
    for (int j = 0; j <= stp; j++)
      v[n++] = 1'b1;
    return inv ? (~v & ((13'h0001 << n) - 13'h0001)) : v;
  endfunction
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [12:0] lv;
    logic [12:0] got;
    int          n;
    int          d;
    int          bt;
    logic        inv;
    logic        hs;
    seed = 32'h0000_0a1d;
    mismatches = 0;
    n_checks = 0;
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, UFBC_MODE_ADDR, 32'h0000_0000, r, e);
    chk("mode reset", r, {16'h0000, UFBC_MODE_RST});
    apb(1'b0, UFBC_DIV_ADDR, 32'h0000_0000, r, e);
    chk("divisor reset", r, {16'h0000, UFBC_DIV_RST});
    apb(1'b0, 12'h020, 32'h0000_0000, r, e);
    chk("unmapped error", {31'h0000_0000, e}, 32'h0000_0001);
    chk("unmapped data", r, 32'h0000_0000);
    // sync character at 64 clocks a bit, sixteen ticks a bit, measures divisor 3
    apb(1'b1, UFBC_MODE_ADDR, 32'h0000_0020, r, e);
    lv = frame_of(32'h0000_0055, 0, 0, 1'b0, n);
    peer.send(lv, n, 64, 1'b1);
    apb(1'b0, UFBC_MODE_ADDR, 32'h0000_0000, r, e);
    chk("auto-baud bit", {31'h0000_0000, r[5]}, 32'h0000_0000);
    apb(1'b0, UFBC_DIV_ADDR, 32'h0000_0000, r, e);
    chk("measured divisor", r, 32'h0000_0003);
    apb(1'b1, UFBC_DIV_ADDR, DIVV, r, e);
    for (int i = 0; i < 16; i++)
    begin
      inv = i[3];
      hs = i[0] ^ i[2];
      bt = (DIVV + 1) * (hs ? 4 : 16);
      if (i == 8)
      begin
        // polarity flip may look like a start bit; drain and discard it
        apb(1'b1, UFBC_MODE_ADDR, 32'h0000_0010, r, e);
        peer.idle_at(1'b0);
        repeat (512) @(posedge clk);
        apb(1'b0, UFBC_RXDATA_ADDR, 32'h0000_0000, r, e);
      end
      apb(1'b1, UFBC_MODE_ADDR, {27'h000_0000, inv, hs, i[1:0], i[2]}, r, e);
      d = int'(xs() & 32'h0000_01ff);
      lv = frame_of(d, i % 4, i / 4 % 2, inv, n);
      exp_q.push_back(d & ((i % 4 == 3) ? 32'h0000_01ff : 32'h0000_00ff));
      apb(1'b1, UFBC_TXDATA_ADDR, d, r, e);
      peer.recv(n, bt, !inv, got);
      chk("tx frame", got, lv);
      peer.send(lv, n, bt, !inv);
      n = 0;
      do
      begin
        apb(1'b0, UFBC_STATUS_ADDR, 32'h0000_0000, r, e);
        n++;
      end
      while (r[2] !== 1'b1 && n < 100);
      chk("rx full", {31'h0000_0000, r[2]}, 32'h0000_0001);
      chk("parity flag", {31'h0000_0000, r[3]}, 32'h0000_0000);
      apb(1'b0, UFBC_RXDATA_ADDR, 32'h0000_0000, r, e);
      chk("rx data", r[8:0], exp_q.pop_front());
    end
    // a corrupted parity bit on an even-parity frame must raise the error flag
    apb(1'b1, UFBC_MODE_ADDR, 32'h0000_0012, r, e);
    d = int'(xs() & 32'h0000_00ff);
    lv = frame_of(d, 1, 0, 1'b1, n);
    lv[9] = ~lv[9];
    exp_q.push_back(d);
    peer.send(lv, n, (DIVV + 1) * 16, 1'b0);
    n = 0;
    do
    begin
      apb(1'b0, UFBC_STATUS_ADDR, 32'h0000_0000, r, e);
      n++;
    end
    while (r[2] !== 1'b1 && n < 100);
    chk("rx full", {31'h0000_0000, r[2]}, 32'h0000_0001);
    chk("parity error", {31'h0000_0000, r[3]}, 32'h0000_0001);
    apb(1'b0, UFBC_RXDATA_ADDR, 32'h0000_0000, r, e);
    chk("rx data", r[8:0], exp_q.pop_front());
    final_report;
  end
endmodule
`default_nettype wire

// ### verilog/ufbc_baud_gen.sv
// ufbc_baud_gen: baud-rate generator, one-cycle tick every div+1 clocks.
// assumes a single clock; div is stable or changes between frames.
`timescale 1ns/1ns
`default_nettype none
module ufbc_baud_gen #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // control
  input  wire logic [WIDTH-1:0] div_i,
  input  wire logic             restart_i,
  // tick out
  output logic                  tick_o
);

  logic [WIDTH-1:0] cnt_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || restart_i)
    begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end
    else if (cnt_r >= div_i)
    begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### verilog/ufbc_pkg.sv
// ufbc_pkg: register map, field positions and reset values of the serial
// mode/baud block. assumes a 32-bit apb slave with word-aligned registers.
package ufbc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] UFBC_MODE_ADDR   = 12'h000;
  localparam logic [11:0] UFBC_DIV_ADDR    = 12'h004;
  localparam logic [11:0] UFBC_TXDATA_ADDR = 12'h008;
  localparam logic [11:0] UFBC_RXDATA_ADDR = 12'h00C;
  localparam logic [11:0] UFBC_STATUS_ADDR = 12'h010;

  // ---------------------------------------------------------------
  // serial_mode_control fields
  // ---------------------------------------------------------------
  localparam int UFBC_AUTO_BAUD_ENABLE_BIT  = 5;
  localparam int UFBC_RXINV_BIT  = 4;
  localparam int UFBC_HSPEED_BIT = 3;
  localparam int UFBC_PDS_LSB    = 1;
  localparam int UFBC_STOP_BIT   = 0;
  localparam logic [15:0] UFBC_MODE_RST = 16'h0000;
  localparam logic [15:0] UFBC_DIV_RST  = 16'h0000;

  // ---------------------------------------------------------------
  // format encodings and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] UFBC_PDS_9N = 2'h3;
  localparam logic [1:0] UFBC_PDS_8O = 2'h2;
  localparam logic [1:0] UFBC_PDS_8E = 2'h1;
  localparam logic [1:0] UFBC_PDS_8N = 2'h0;
  localparam logic [4:0] UFBC_OVS_HS = 5'h04;
  localparam logic [4:0] UFBC_OVS_STD = 5'h10;
  localparam logic [7:0] UFBC_SYNC_CHAR = 8'h55;
  localparam int UFBC_SYNC_EDGES = 5;

endpackage

// ### verilog/ufbc_top.sv
// ufbc_top: serial port with mode register, frame formatter, receiver and
// auto-baud measurement. assumes apb master; serial lines synchronous to clk.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ufbc_top
  import ufbc_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // serial lines
  input  wire logic        serial_receive_line_i,
  output logic             serial_transmit_line_o
);

  typedef enum logic [2:0] {
    UFBC_IDLE   = 3'b000,
    UFBC_START  = 3'b001,
    UFBC_DATA   = 3'b010,
    UFBC_PARITY = 3'b011,
    UFBC_STOP   = 3'b100
  } ufbc_state_type;

  // ---------------------------------------------------------------
  // registers and decode
  // ---------------------------------------------------------------
  logic [15:0]          mode_r;
  logic [DIV_WIDTH-1:0] div_r;
  logic [8:0]           rx_data_r;
  logic                 rx_full_r;
  logic                 rx_perr_r;
  logic [8:0]           tx_hold_r;
  logic                 tx_pend_r;
  logic                 tx_busy;
  logic                 wr_en;
  logic                 rd_en;
  logic                 auto_baud_enable_done;
  logic [DIV_WIDTH-1:0] auto_baud_enable_div;
  logic                 rx_done;
  logic                 ab_skip_r;

  function automatic logic [3:0] ufbc_nbits(input logic [1:0] pds);
    ufbc_nbits = (pds == UFBC_PDS_9N) ? 4'h9 : 4'h8;
  endfunction

  function automatic logic ufbc_has_par(input logic [1:0] pds);
    ufbc_has_par = (pds == UFBC_PDS_8O) || (pds == UFBC_PDS_8E);
  endfunction

  function automatic logic ufbc_par(input logic [8:0] d, input logic [1:0] pds);
    ufbc_par = ^d[7:0] ^ (pds == UFBC_PDS_8O);
  endfunction

  wire logic [1:0] pds     = mode_r[UFBC_PDS_LSB+1:UFBC_PDS_LSB];
  wire logic       idle_lv = ~mode_r[UFBC_RXINV_BIT];
  wire logic       rx_bit  = serial_receive_line_i ^ mode_r[UFBC_RXINV_BIT];
  wire logic [4:0] ovs     = mode_r[UFBC_HSPEED_BIT] ? UFBC_OVS_HS : UFBC_OVS_STD;

  // a write lands at the edge that completes the access, with pready high
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_en = psel_i && penable_i && !pwrite_i && !pready_o;

  // one wait state: pready high in the second access cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i && penable_i && !pready_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      mode_r <= UFBC_MODE_RST;
    else if (wr_en && paddr_i == UFBC_MODE_ADDR)
      mode_r <= pwdata_i[15:0] & 16'h003F;
    else if (auto_baud_enable_done)
      mode_r[UFBC_AUTO_BAUD_ENABLE_BIT] <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      div_r <= UFBC_DIV_RST[DIV_WIDTH-1:0];
    else if (auto_baud_enable_done)
      div_r <= auto_baud_enable_div;
    else if (wr_en && paddr_i == UFBC_DIV_ADDR)
      div_r <= pwdata_i[DIV_WIDTH-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      if (paddr_i == UFBC_MODE_ADDR)
        prdata_o <= {16'h0000, mode_r};
      else if (paddr_i == UFBC_DIV_ADDR)
        prdata_o[DIV_WIDTH-1:0] <= div_r;
      else if (paddr_i == UFBC_TXDATA_ADDR)
        prdata_o <= {23'h00_0000, tx_hold_r};
      else if (paddr_i == UFBC_RXDATA_ADDR)
        prdata_o <= {23'h00_0000, rx_data_r};
      else if (paddr_i == UFBC_STATUS_ADDR)
        prdata_o <= {28'h000_0000, rx_perr_r, rx_full_r, tx_pend_r, tx_busy};
      else
        pslverr_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // baud generator shared by transmitter and receiver
  // ---------------------------------------------------------------
  logic tick;
  ufbc_baud_gen #(.WIDTH(DIV_WIDTH)) u_bgen (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .div_i     (div_r),
    .restart_i (auto_baud_enable_done),
    .tick_o    (tick)
  );

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  ufbc_state_type tx_st_r;
  logic [4:0]     tx_ovs_r;
  logic [3:0]     tx_idx_r;
  logic [8:0]     tx_sh_r;
  logic           tx_stop2_r;
  wire  logic     tx_bit_end = tick && (tx_ovs_r == ovs - 5'h01);
  assign tx_busy = (tx_st_r != UFBC_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_hold_r <= 9'h000;
      tx_pend_r <= 1'b0;
    end
    else if (wr_en && paddr_i == UFBC_TXDATA_ADDR)
    begin
      tx_hold_r <= pwdata_i[8:0];
      tx_pend_r <= 1'b1;
    end
    else if (!tx_busy && tx_pend_r)
      tx_pend_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_st_r                <= UFBC_IDLE;
      tx_ovs_r               <= 5'h00;
      tx_idx_r               <= 4'h0;
      tx_sh_r                <= 9'h000;
      tx_stop2_r             <= 1'b0;
      serial_transmit_line_o <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_ovs_r <= tx_bit_end ? 5'h00 : tx_ovs_r + 5'h01;
      case (tx_st_r)
        UFBC_IDLE:
        begin
          serial_transmit_line_o <= idle_lv;
          tx_ovs_r <= 5'h00;
          if (tx_pend_r)
          begin
            tx_sh_r                <= tx_hold_r;
            tx_idx_r               <= 4'h0;
            tx_stop2_r             <= mode_r[UFBC_STOP_BIT];
            serial_transmit_line_o <= ~idle_lv;
            tx_st_r                <= UFBC_START;
          end
        end
        UFBC_START:
          if (tx_bit_end)
          begin
            serial_transmit_line_o <= tx_sh_r[0] ^ ~idle_lv;
            tx_st_r                <= UFBC_DATA;
          end
        UFBC_DATA:
          if (tx_bit_end)
          begin
            if (tx_idx_r == ufbc_nbits(pds) - 4'h1)
            begin
              if (ufbc_has_par(pds))
              begin
                serial_transmit_line_o <= ufbc_par(tx_sh_r, pds) ^ ~idle_lv;
                tx_st_r                <= UFBC_PARITY;
              end
              else
              begin
                serial_transmit_line_o <= idle_lv;
                tx_st_r                <= UFBC_STOP;
              end
            end
            else
            begin
              tx_idx_r               <= tx_idx_r + 4'h1;
              serial_transmit_line_o <= tx_sh_r[tx_idx_r + 4'h1] ^ ~idle_lv;
            end
          end
        UFBC_PARITY:
          if (tx_bit_end)
          begin
            serial_transmit_line_o <= idle_lv;
            tx_st_r                <= UFBC_STOP;
          end
        default:
          if (tx_bit_end)
          begin
            if (tx_stop2_r)
              tx_stop2_r <= 1'b0;
            else
              tx_st_r <= UFBC_IDLE;
          end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receiver, samples mid-bit; rx_bit is 1 at idle after polarity fix
  // ---------------------------------------------------------------
  ufbc_state_type rx_st_r;
  logic [4:0]     rx_ovs_r;
  logic [3:0]     rx_idx_r;
  logic [8:0]     rx_sh_r;
  logic           rx_pbit_r;
  wire  logic     rx_mid = tick && (rx_ovs_r == (ovs >> 1));
  wire  logic     rx_end = tick && (rx_ovs_r == ovs - 5'h01);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_st_r   <= UFBC_IDLE;
      rx_ovs_r  <= 5'h00;
      rx_idx_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_pbit_r <= 1'b0;
    end
    else
    begin
      if (tick)
        rx_ovs_r <= rx_end ? 5'h00 : rx_ovs_r + 5'h01;
      case (rx_st_r)
        UFBC_IDLE:
        begin
          rx_ovs_r <= 5'h00;
          // auto-baud owns the line while it measures
          if (!rx_bit && !mode_r[UFBC_AUTO_BAUD_ENABLE_BIT] && !ab_skip_r)
          begin
            rx_idx_r <= 4'h0;
            rx_sh_r  <= 9'h000;
            rx_st_r  <= UFBC_START;
          end
        end
        UFBC_START:
          if (rx_mid && rx_bit)
            rx_st_r <= UFBC_IDLE;
          else if (rx_end)
            rx_st_r <= UFBC_DATA;
        UFBC_DATA:
        begin
          if (rx_mid)
            rx_sh_r[rx_idx_r] <= rx_bit;
          if (rx_end)
          begin
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == ufbc_nbits(pds) - 4'h1)
              rx_st_r <= ufbc_has_par(pds) ? UFBC_PARITY : UFBC_STOP;
          end
        end
        UFBC_PARITY:
        begin
          if (rx_mid)
            rx_pbit_r <= rx_bit;
          if (rx_end)
            rx_st_r <= UFBC_STOP;
        end
        default:
          if (rx_mid)
            rx_st_r <= UFBC_IDLE;
      endcase
    end
  end

  assign rx_done = (rx_st_r == UFBC_STOP) && rx_mid;

  // reading the data register frees it; a new frame wins over that clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_data_r <= 9'h000;
      rx_full_r <= 1'b0;
      rx_perr_r <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_data_r <= rx_sh_r;
      rx_full_r <= 1'b1;
      rx_perr_r <= ufbc_has_par(pds) && (rx_pbit_r != ufbc_par(rx_sh_r, pds));
    end
    else if (rd_en && paddr_i == UFBC_RXDATA_ADDR)
      rx_full_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // auto-baud: 55h gives five falling edges, start to bit 7, eight bits
  // ---------------------------------------------------------------
  logic [2:0]           ab_edges_r;
  logic [DIV_WIDTH+4:0] ab_cnt_r;
  logic                 rx_prev_r;
  wire  logic           rx_fall = rx_prev_r && !rx_bit;
  wire  logic [DIV_WIDTH+4:0] ab_q = mode_r[UFBC_HSPEED_BIT] ? (ab_cnt_r >> 5) : (ab_cnt_r >> 7);

  assign auto_baud_enable_done = mode_r[UFBC_AUTO_BAUD_ENABLE_BIT] && rx_fall
                      && (ab_edges_r == 3'(UFBC_SYNC_EDGES - 1));
  assign auto_baud_enable_div  = (ab_q[DIV_WIDTH-1:0] == '0) ? '0 : ab_q[DIV_WIDTH-1:0] - 1'b1;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_prev_r  <= 1'b1;
      ab_edges_r <= 3'h0;
      ab_cnt_r   <= '0;
      ab_skip_r  <= 1'b0;
    end
    else
    begin
      rx_prev_r <= rx_bit;
      // the tail of the sync character must not reach the receiver
      if (auto_baud_enable_done)
        ab_skip_r <= 1'b1;
      else if (rx_bit)
        ab_skip_r <= 1'b0;
      if (!mode_r[UFBC_AUTO_BAUD_ENABLE_BIT] || auto_baud_enable_done)
      begin
        ab_edges_r <= 3'h0;
        ab_cnt_r   <= '0;
      end
      else if (rx_fall && ab_edges_r == 3'h0)
      begin
        // the first edge's cycle counts, so eight bits give an exact multiple
        ab_edges_r <= 3'h1;
        ab_cnt_r   <= {{(DIV_WIDTH+4){1'b0}}, 1'b1};
      end
      else if (ab_edges_r != 3'h0)
      begin
        ab_cnt_r <= ab_cnt_r + 1'b1;
        if (rx_fall)
          ab_edges_r <= ab_edges_r + 3'h1;
      end
    end
  end

endmodule
`default_nettype wire
